// File: inc/drcgp_defs.svh
// Constants for the dual-rank command gate and power-state block.
// Assumes nothing; included by the package, the top module and the controller model.
`ifndef DRCGP_DEFS_SVH
`define DRCGP_DEFS_SVH

`define DRCGP_RANKS     2
`define DRCGP_ADDR_W    17
`define DRCGP_BG_W      2
`define DRCGP_BA_W      2
`define DRCGP_CODE_W    4
// {act_n, ras_n, cas_n, we_n} of a refresh, which enters self-refresh when paired with clock gate low
`define DRCGP_CODE_REF  4'h9

`endif

// File: inc/drcgp_pkg.sv
// Types shared by the dual-rank command gate and power-state block.
// Assumes drcgp_defs.svh is on the include path.
`include "drcgp_defs.svh"

package drcgp_pkg;

	typedef struct packed {
		logic clock_gate;
		logic select_n;
		logic term_enable;
	} drcgp_rank_pins_s;

	typedef struct packed {
		logic                      select_n;
		logic [`DRCGP_CODE_W-1:0]  code;
		logic [`DRCGP_BG_W-1:0]    bank_group;
		logic [`DRCGP_BA_W-1:0]    bank;
		logic [`DRCGP_ADDR_W-1:0]  addr;
	} drcgp_cmd_s;

	typedef enum logic [1:0] {
		DRCGP_ACTIVE,
		DRCGP_PRE_PD,
		DRCGP_ACT_PD,
		DRCGP_SELF_REF
	} drcgp_pwr_e;

endpackage

// File: logic/drcgp_sync.sv
// Two flip-flop level synchroniser, one bit per lane.
// Assumes each lane is a level that holds for several destination clocks.
`timescale 1ns/1ps

module drcgp_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_ff;

	// The first stage feeds only the second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_ff <= '0;
			dout    <= '0;
		end else begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end

endmodule

// File: logic/drcgp_top.sv
// Command gating and clock-gate power states for a two-rank memory device.
// Assumes link pins are launched by the controller off link_clk; core-side inputs are on core_clk.
`timescale 1ns/1ps
`include "drcgp_defs.svh"

// Function
// - Every address and control pin is captured on the rising edge of the link clock.
// - A rank's clocks, input buffers and drivers run while its clock gate is high and stop when it is low.
// - Clock gate low with all banks idle enters precharge power-down or self-refresh; banks must be idle first.
// - Clock gate low with any row open enters active power-down.
// - Self-refresh is left when the clock gate is registered high on a link clock edge.
// - In power-down only clock, termination-enable and clock-gate inputs stay live.
// - In self-refresh only the clock-gate inputs stay live; clock, command and termination are ignored.
// - A rank ignores the command on any edge where its select is registered high.
// - The select level is decoded as one bit of the command code on the same edge.
// - Each rank has its own select, termination enable, clock gate and power state; rank 0 wins when both are selected.
// - A registered-high termination enable turns on nominal termination unless it is disabled by mode.
module drcgp_top (
	input  wire logic                                      core_clk,
	input  wire logic                                      resetn,
	input  wire logic                                      link_clk,
	input  wire drcgp_pkg::drcgp_rank_pins_s [`DRCGP_RANKS-1:0] rank_pins,
	input  wire drcgp_pkg::drcgp_cmd_s                     cmd_pins,
	input  wire logic [`DRCGP_RANKS-1:0]                   bank_open,
	input  wire logic                                      nominal_termination,
	output logic                                           cmd_valid,
	output logic                                           cmd_rank,
	output drcgp_pkg::drcgp_cmd_s                          cmd_word,
	output logic [`DRCGP_RANKS-1:0]                        rank_clock_on,
	output logic [`DRCGP_RANKS-1:0]                        rank_pre_pd,
	output logic [`DRCGP_RANKS-1:0]                        rank_act_pd,
	output logic [`DRCGP_RANKS-1:0]                        rank_self_ref,
	output logic [`DRCGP_RANKS-1:0]                        rank_term_on
);

	localparam int NR  = `DRCGP_RANKS;
	localparam int STW = 5 * NR + 1;

	function automatic logic is_refresh(input drcgp_pkg::drcgp_cmd_s c);
		is_refresh = !c.select_n && (c.code == `DRCGP_CODE_REF);
	endfunction

	// ---------------- Link domain ----------------
	drcgp_pkg::drcgp_rank_pins_s [NR-1:0] cap_pins_ff;
	drcgp_pkg::drcgp_cmd_s                cap_cmd_ff;
	drcgp_pkg::drcgp_cmd_s                hold_cmd_ff;
	drcgp_pkg::drcgp_pwr_e                st_ff  [NR];
	drcgp_pkg::drcgp_pwr_e                nxt_st [NR];
	logic [NR-1:0]                        term_ff;
	logic [NR-1:0]                        nxt_term;
	logic [NR-1:0]                        accept;
	logic                                 hold_rank_ff;
	logic                                 tgl_ff;
	logic [NR:0]                          link_in_sync;
	logic [NR-1:0]                        open_l;
	logic                                 term_mode_l;

	drcgp_sync #(.WIDTH(NR + 1)) u_to_link (
		.clk    (link_clk),
		.resetn (resetn),
		.din    ({nominal_termination, bank_open}),
		.dout   (link_in_sync)
	);

	assign open_l      = link_in_sync[NR-1:0];
	assign term_mode_l = link_in_sync[NR];

	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			cap_pins_ff <= '0;
			cap_cmd_ff  <= '0;
		end else begin
			cap_pins_ff <= rank_pins;
			cap_cmd_ff  <= cmd_pins;
		end
	end

	// Per-rank command acceptance: select is part of the decoded code, and a rank out of the
	// active state has its command buffers off. Rank 0 wins if the controller selects both.
	assign accept[0] = (st_ff[0] == drcgp_pkg::DRCGP_ACTIVE) && cap_pins_ff[0].clock_gate
	                   && !cap_pins_ff[0].select_n;
	assign accept[1] = (st_ff[1] == drcgp_pkg::DRCGP_ACTIVE) && cap_pins_ff[1].clock_gate
	                   && !cap_pins_ff[1].select_n && !accept[0];

	always_comb begin
		for (int r = 0; r < NR; r++) begin
			nxt_st[r] = st_ff[r];
			unique case (st_ff[r])
				drcgp_pkg::DRCGP_ACTIVE: begin
					if (!cap_pins_ff[r].clock_gate) begin
						if (open_l[r])
							nxt_st[r] = drcgp_pkg::DRCGP_ACT_PD;
						else if (is_refresh({cap_pins_ff[r].select_n, cap_cmd_ff.code,
						                     cap_cmd_ff.bank_group, cap_cmd_ff.bank, cap_cmd_ff.addr}))
							nxt_st[r] = drcgp_pkg::DRCGP_SELF_REF;
						else
							nxt_st[r] = drcgp_pkg::DRCGP_PRE_PD;
					end
				end
				drcgp_pkg::DRCGP_PRE_PD,
				drcgp_pkg::DRCGP_ACT_PD: begin
					if (cap_pins_ff[r].clock_gate)
						nxt_st[r] = drcgp_pkg::DRCGP_ACTIVE;
				end
				drcgp_pkg::DRCGP_SELF_REF: begin
					if (cap_pins_ff[r].clock_gate)
						nxt_st[r] = drcgp_pkg::DRCGP_ACTIVE;
				end
			endcase
			// Termination stays live in power-down, dead in self-refresh
			nxt_term[r] = cap_pins_ff[r].term_enable && term_mode_l
			              && (st_ff[r] != drcgp_pkg::DRCGP_SELF_REF);
		end
	end

	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			for (int r = 0; r < NR; r++)
				st_ff[r] <= drcgp_pkg::DRCGP_ACTIVE;
			term_ff <= '0;
		end else begin
			for (int r = 0; r < NR; r++)
				st_ff[r] <= nxt_st[r];
			term_ff <= nxt_term;
		end
	end

	// Hold register is read by the core only after the toggle has crossed, so it is stable then
	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			hold_cmd_ff  <= '0;
			hold_rank_ff <= 1'b0;
			tgl_ff       <= 1'b0;
		end else if (|accept) begin
			hold_cmd_ff  <= cap_cmd_ff;
			hold_cmd_ff.select_n <= 1'b0;
			hold_rank_ff <= accept[1];
			tgl_ff       <= !tgl_ff;
		end
	end

	// ---------------- Core domain ----------------
	logic [STW-1:0] st_flags;
	logic [STW-1:0] st_flags_ff;
	logic [STW-1:0] st_sync;
	logic           tgl_seen_ff;
	logic           new_cmd;

	always_comb begin
		st_flags = '0;
		for (int r = 0; r < NR; r++) begin
			// Carried as "rank down" so the synchroniser's zero reset matches a rank that is up
			st_flags[r]          = (st_ff[r] != drcgp_pkg::DRCGP_ACTIVE);
			st_flags[NR + r]     = (st_ff[r] == drcgp_pkg::DRCGP_PRE_PD);
			st_flags[2 * NR + r] = (st_ff[r] == drcgp_pkg::DRCGP_ACT_PD);
			st_flags[3 * NR + r] = (st_ff[r] == drcgp_pkg::DRCGP_SELF_REF);
			st_flags[4 * NR + r] = term_ff[r];
		end
		st_flags[STW-1] = tgl_ff;
	end

	// Registered in the link domain so the synchroniser never samples a decode glitch
	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn)
			st_flags_ff <= '0;
		else
			st_flags_ff <= st_flags;
	end

	drcgp_sync #(.WIDTH(STW)) u_to_core (
		.clk    (core_clk),
		.resetn (resetn),
		.din    (st_flags_ff),
		.dout   (st_sync)
	);

	assign new_cmd = st_sync[STW-1] ^ tgl_seen_ff;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tgl_seen_ff   <= 1'b0;
			cmd_valid     <= 1'b0;
			cmd_rank      <= 1'b0;
			cmd_word      <= '0;
			rank_clock_on <= '1;
			rank_pre_pd   <= '0;
			rank_act_pd   <= '0;
			rank_self_ref <= '0;
			rank_term_on  <= '0;
		end else begin
			tgl_seen_ff   <= st_sync[STW-1];
			cmd_valid     <= new_cmd;
			if (new_cmd) begin
				cmd_rank <= hold_rank_ff;
				cmd_word <= hold_cmd_ff;
			end
			rank_clock_on <= ~st_sync[NR-1:0];
			rank_pre_pd   <= st_sync[2*NR-1:NR];
			rank_act_pd   <= st_sync[3*NR-1:2*NR];
			rank_self_ref <= st_sync[4*NR-1:3*NR];
			rank_term_on  <= st_sync[5*NR-1:4*NR];
		end
	end

	// ---------------- Checks ----------------
	AST_CAPTURE: assert property (@(posedge link_clk) disable iff (!resetn)
		##1 cap_cmd_ff == $past(cmd_pins)) else $error("command pins not captured on link edge");
	AST_GATE_OFF: assert property (@(posedge link_clk) disable iff (!resetn)
		(st_ff[0] == drcgp_pkg::DRCGP_ACTIVE && !cap_pins_ff[0].clock_gate)
		|=> st_ff[0] != drcgp_pkg::DRCGP_ACTIVE) else $error("rank stayed active with gate low");
	AST_PRE_PD: assert property (@(posedge link_clk) disable iff (!resetn)
		(st_ff[0] == drcgp_pkg::DRCGP_ACTIVE && !cap_pins_ff[0].clock_gate && !open_l[0]
		 && cap_pins_ff[0].select_n) |=> st_ff[0] == drcgp_pkg::DRCGP_PRE_PD)
		else $error("idle rank did not enter precharge power-down");
	AST_ACT_PD: assert property (@(posedge link_clk) disable iff (!resetn)
		(st_ff[0] == drcgp_pkg::DRCGP_ACTIVE && !cap_pins_ff[0].clock_gate && open_l[0])
		|=> st_ff[0] == drcgp_pkg::DRCGP_ACT_PD) else $error("open row did not give active power-down");
	AST_SR_EXIT: assert property (@(posedge link_clk) disable iff (!resetn)
		(st_ff[1] == drcgp_pkg::DRCGP_SELF_REF && cap_pins_ff[1].clock_gate)
		|=> st_ff[1] == drcgp_pkg::DRCGP_ACTIVE) else $error("self-refresh exit not taken");
	AST_PD_TERM: assert property (@(posedge link_clk) disable iff (!resetn)
		(st_ff[1] == drcgp_pkg::DRCGP_PRE_PD && cap_pins_ff[1].term_enable && term_mode_l)
		|=> term_ff[1]) else $error("termination dropped in power-down");
	AST_SR_IGNORE: assert property (@(posedge link_clk) disable iff (!resetn)
		(st_ff[1] == drcgp_pkg::DRCGP_SELF_REF) |-> !accept[1] ##1 !term_ff[1])
		else $error("input honoured in self-refresh");
	AST_CS_MASK: assert property (@(posedge link_clk) disable iff (!resetn)
		cap_pins_ff[1].select_n |=> $stable(tgl_ff) || $past(accept[0]))
		else $error("deselected rank took a command");
	AST_HOLD: assert property (@(posedge link_clk) disable iff (!resetn)
		accept[1] |=> hold_rank_ff && hold_cmd_ff.code == $past(cap_cmd_ff.code))
		else $error("accepted command not held");
	AST_TERM_MODE: assert property (@(posedge link_clk) disable iff (!resetn)
		!term_mode_l |=> !term_ff[0] && !term_ff[1]) else $error("termination on while disabled by mode");
	AST_PULSE: assert property (@(posedge core_clk) disable iff (!resetn)
		cmd_valid |=> !cmd_valid) else $error("command strobe longer than one cycle");

endmodule

// File: test/drcgp_ctl_model.sv
// Controller model: drives both ranks' link pins, changing them just after a link edge.
// Assumes the bench calls its tasks and keeps banks idle before a self-refresh request.
`timescale 1ns/1ps
`include "drcgp_defs.svh"

module drcgp_ctl_model (
	input  wire logic                                      link_clk,
	output drcgp_pkg::drcgp_rank_pins_s [`DRCGP_RANKS-1:0] rank_pins,
	output drcgp_pkg::drcgp_cmd_s                          cmd_pins
);
	initial begin
		rank_pins = {2{3'b110}};
		cmd_pins  = '0;
	end

	// Select only the ranks in sel for one link cycle
	task automatic send(input logic [1:0] sel, input logic [3:0] code, input logic [16:0] addr);
		@(posedge link_clk);
		rank_pins[0].select_n <= ~sel[0];
		rank_pins[1].select_n <= ~sel[1];
		cmd_pins <= {~|sel, code, addr[3:0], addr};
		@(posedge link_clk);
		rank_pins[0].select_n <= 1'b1;
		rank_pins[1].select_n <= 1'b1;
		// Released lines show the inverse, never a stale copy
		cmd_pins <= ~{~|sel, code, addr[3:0], addr};
	endtask

	task automatic gate(input int r, input logic v);
		@(posedge link_clk);
		rank_pins[r].clock_gate <= v;
	endtask

	task automatic term(input int r, input logic v);
		@(posedge link_clk);
		rank_pins[r].term_enable <= v;
	endtask

	// Refresh code with clock gate low on the same edge
	task automatic selfref(input int r);
		@(posedge link_clk);
		rank_pins[r].clock_gate <= 1'b0;
		rank_pins[r].select_n   <= 1'b0;
		cmd_pins.code           <= `DRCGP_CODE_REF;
		@(posedge link_clk);
		rank_pins[r].select_n   <= 1'b1;
		cmd_pins.code           <= ~`DRCGP_CODE_REF;
	endtask
endmodule

// File: test/dual_rank_cmd_gate_power_tb_top.sv
// Testbench: command gating and power states of both ranks.
// Assumes the controller model owns the link pins; core-side levels are driven here.
`timescale 1ns/1ps

module dual_rank_cmd_gate_power_tb_top;
	logic                                  core_clk            = 1'b0;
	logic                                  link_clk            = 1'b0;
	logic                                  resetn              = 1'b0;
	logic [1:0]                            bank_open           = 2'b00;
	logic                                  nominal_termination = 1'b0;
	drcgp_pkg::drcgp_rank_pins_s [1:0]     rank_pins;
	drcgp_pkg::drcgp_cmd_s                 cmd_pins;
	drcgp_pkg::drcgp_cmd_s                 cmd_word;
	logic                                  cmd_valid;
	logic                                  cmd_rank;
	logic [1:0]                            rank_clock_on;
	logic [1:0]                            rank_pre_pd;
	logic [1:0]                            rank_act_pd;
	logic [1:0]                            rank_self_ref;
	logic [1:0]                            rank_term_on;
	int                                    bad_count           = 0;
	int                                    tests_run           = 0;

	always #25 core_clk = ~core_clk;
	// Different period keeps the link clock drifting against the core
	always #24 link_clk = ~link_clk;

	drcgp_ctl_model ctl (.link_clk(link_clk), .rank_pins(rank_pins), .cmd_pins(cmd_pins));

	drcgp_top uut (.core_clk(core_clk), .resetn(resetn), .link_clk(link_clk), .rank_pins(rank_pins),
		.cmd_pins(cmd_pins), .bank_open(bank_open), .nominal_termination(nominal_termination),
		.cmd_valid(cmd_valid), .cmd_rank(cmd_rank), .cmd_word(cmd_word), .rank_clock_on(rank_clock_on),
		.rank_pre_pd(rank_pre_pd), .rank_act_pd(rank_act_pd), .rank_self_ref(rank_self_ref),
		.rank_term_on(rank_term_on));

	task automatic summarize;
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk_lvl(input logic [1:0] got, input logic [1:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: level %b, expected %b", $time, got, exp);
		end
	endtask

	task automatic chk_word(input drcgp_pkg::drcgp_cmd_s got, input drcgp_pkg::drcgp_cmd_s exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: command %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic settle;
		repeat (10) @(posedge core_clk);
		#1;
	endtask

	// Send one command and judge whether and how it is taken
	task automatic cmd_case(input logic [1:0] sel, input logic ok, input logic [3:0] code, input logic [16:0] addr);
		drcgp_pkg::drcgp_cmd_s exp;
		int n;
		exp = {1'b0, code, addr[3:0], addr};
		ok = ok && (sel != 2'b00);
		ctl.send(sel, code, addr);
		n = 0;
		while (cmd_valid !== 1'b1 && n < 12) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk_lvl({1'b0, cmd_valid}, {1'b0, ok});
		if (ok) begin
			chk_word(cmd_word, exp);
			chk_lvl({1'b0, cmd_rank}, {1'b0, ~sel[0]});
			if (cmd_valid !== 1'b1)
				summarize;
		end
		settle;
	endtask

	task automatic scn_cmds;
		chk_lvl(rank_clock_on, 2'b11);
		chk_lvl(rank_pre_pd | rank_act_pd | rank_self_ref, 2'b00);
		cmd_case(2'b01, 1'b1, 4'hc, 17'h1a5a5);
		cmd_case(2'b10, 1'b1, 4'h3, 17'h05a5a);
		cmd_case(2'b11, 1'b1, 4'h6, 17'h1ffff);
		cmd_case(2'b00, 1'b1, 4'h0, 17'h00000);
	endtask

	task automatic scn_pd;
		ctl.gate(0, 1'b0);
		settle;
		chk_lvl(rank_pre_pd, 2'b01);
		chk_lvl(rank_clock_on, 2'b10);
		cmd_case(2'b01, 1'b0, 4'hc, 17'h00123);
		cmd_case(2'b10, 1'b1, 4'h5, 17'h00321);
		ctl.gate(0, 1'b1);
		settle;
		chk_lvl(rank_clock_on, 2'b11);
		@(posedge core_clk) bank_open <= 2'b01;
		settle;
		ctl.gate(0, 1'b0);
		settle;
		chk_lvl(rank_act_pd, 2'b01);
		chk_lvl(rank_pre_pd, 2'b00);
		ctl.gate(0, 1'b1);
		@(posedge core_clk) bank_open <= 2'b00;
		settle;
		chk_lvl(rank_act_pd, 2'b00);
	endtask

	task automatic scn_sr;
		@(posedge core_clk) nominal_termination <= 1'b1;
		ctl.term(1, 1'b1);
		settle;
		chk_lvl(rank_term_on, 2'b10);
		ctl.selfref(1);
		settle;
		chk_lvl(rank_self_ref, 2'b10);
		chk_lvl(rank_term_on, 2'b00);
		cmd_case(2'b10, 1'b0, 4'h3, 17'h00777);
		ctl.gate(1, 1'b1);
		settle;
		chk_lvl(rank_self_ref, 2'b00);
		chk_lvl(rank_term_on, 2'b10);
		ctl.gate(1, 1'b0);
		settle;
		chk_lvl(rank_pre_pd, 2'b10);
		chk_lvl(rank_term_on, 2'b10);
		@(posedge core_clk) nominal_termination <= 1'b0;
		settle;
		chk_lvl(rank_term_on, 2'b00);
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (6) @(posedge core_clk);
		scn_cmds;
		scn_pd;
		scn_sr;
		summarize;
	end
endmodule
